// ---- include/cce_pkg.sv ----
// Package for the call and clear instruction execution block
package cce_pkg;
    // ==========================================
    // Widths
    localparam int PC_W = 11;
    localparam int DADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int BITSEL_W = 3;
    // ==========================================
    // Constants
    localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
    localparam logic [PC_W-1:0] PC_STEP = 11'h001;
    localparam logic [PC_W-1:0] PC_RESET = 11'h000;
    localparam logic [DADDR_W-1:0] DADDR_RESET = 8'h00;
    localparam logic [BITSEL_W-1:0] BITSEL_RESET = 3'h0;

    // ==========================================
    // Operations
    typedef enum logic [2:0]
    {
        OP_NONE = 3'h0,
        OP_CALL = 3'h1,
        OP_MEM_ZERO = 3'h2,
        OP_BIT_ZERO = 3'h3,
        OP_WD_CLEAR = 3'h4,
        OP_WD_PRE1 = 3'h5,
        OP_WD_PRE2 = 3'h6
    } cce_op_type;

    // Decoded instruction request
    typedef struct packed
    {
        cce_op_type op;
        logic [PC_W-1:0] target;
        logic [DADDR_W-1:0] addr;
        logic [BITSEL_W-1:0] bit_sel;
    } cce_req_type;

    // Data memory write port
    typedef struct packed
    {
        logic we;
        logic [DADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cce_mem_type;

    // Pre-clear pairing tracker states
    typedef enum logic [2:0]
    {
        PRE_IDLE = 3'b001,
        PRE_FIRST = 3'b010,
        PRE_SECOND = 3'b100
    } cce_pre_type;
endpackage

// ---- verilog/cce_preclear.sv ----
// Pairing tracker for the two watchdog pre-clear operations
`timescale 1ns/1ps
module cce_preclear
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // Operation strobes
    input wire logic pre1_i,
    input wire logic pre2_i,
    // Pair completed
    output logic fire_o
);
    cce_pkg::cce_pre_type state;

    // ==========================================
    // Tracker
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            state <= cce_pkg::PRE_IDLE;
        end
        else if (pre1_i)
        begin
            state <= cce_pkg::PRE_FIRST;
        end
        else if (pre2_i)
        begin
            state <= cce_pkg::PRE_SECOND;
        end
    end

    // Fires only on the opposite op; a repeat does nothing
    assign fire_o = (pre1_i && state == cce_pkg::PRE_SECOND)
        || (pre2_i && state == cce_pkg::PRE_FIRST);

    chk_repeat_first_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pre1_i ##1 pre1_i |-> !fire_o)
        else $error("repeated first pre-clear fired");
    chk_repeat_second_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pre2_i && !pre1_i ##1 pre2_i && !pre1_i |-> !fire_o)
        else $error("repeated second pre-clear fired");
    chk_pair_fires: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pre1_i ##1 (pre2_i && !pre1_i) |-> fire_o)
        else $error("alternated pair did not fire");
endmodule

// ---- verilog/cce_exec.sv ----
// Execution of call, memory clear and watchdog clear operations
`timescale 1ns/1ps
// Functional notes
// - call pushes pc plus one, loads target
// - call takes two instruction cycles
// - memory clear writes zero byte, flags untouched
// - bit clear zeroes only selected bit
// - watchdog clear resets counter, timeout, powerdown
// - alternated pre-clear pair clears watchdog and flags
// - repeated first pre-clear has no effect
// - repeated second pre-clear has no effect
module cce_exec
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic NRST_I,
    // Decoded request and core state
    input wire logic REQ_VALID_I,
    input wire cce_pkg::cce_req_type REQ_I,
    input wire logic [cce_pkg::PC_W-1:0] PC_I,
    input wire logic [cce_pkg::DATA_W-1:0] MEM_RDATA_I,
    // Core control
    output logic BUSY_O,
    output logic DONE_O,
    output logic PC_LOAD_O,
    output logic [cce_pkg::PC_W-1:0] PC_O,
    output logic PUSH_O,
    output logic [cce_pkg::PC_W-1:0] PUSH_DATA_O,
    // Data memory
    output cce_pkg::cce_mem_type MEM_O,
    // Watchdog
    output logic WDT_CLEAR_O,
    output logic TIMEOUT_CLR_O,
    output logic POWERDOWN_CLR_O
);
    logic call_second;
    logic take;
    logic pre_fire;
    logic wd_clear;
    logic take_call;
    logic take_mem_zero;
    logic take_bit_zero;
    logic take_wd_clear;
    logic take_pre1;
    logic take_pre2;

    // ==========================================
    // Decoding
    function automatic logic op_taken(input logic taken, input cce_pkg::cce_req_type req,
        input cce_pkg::cce_op_type op);
        return taken && req.op == op;
    endfunction

    // Requests are ignored during the second call cycle
    assign take = REQ_VALID_I && !call_second;
    assign take_call = op_taken(take, REQ_I, cce_pkg::OP_CALL);
    assign take_mem_zero = op_taken(take, REQ_I, cce_pkg::OP_MEM_ZERO);
    assign take_bit_zero = op_taken(take, REQ_I, cce_pkg::OP_BIT_ZERO);
    assign take_wd_clear = op_taken(take, REQ_I, cce_pkg::OP_WD_CLEAR);
    assign take_pre1 = op_taken(take, REQ_I, cce_pkg::OP_WD_PRE1);
    assign take_pre2 = op_taken(take, REQ_I, cce_pkg::OP_WD_PRE2);

    // ==========================================
    // Pre-clear pairing
    cce_preclear u_pre
    (
        .clk_i(SYS_CLK_I),
        .nrst_i(NRST_I),
        .pre1_i(take_pre1),
        .pre2_i(take_pre2),
        .fire_o(pre_fire)
    );

    assign wd_clear = take_wd_clear || pre_fire;

    // ==========================================
    // Call sequencing
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            call_second <= 1'b0;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
            PC_LOAD_O <= 1'b0;
            PC_O <= cce_pkg::PC_RESET;
            PUSH_O <= 1'b0;
            PUSH_DATA_O <= cce_pkg::PC_RESET;
        end
        else
        begin
            // Push lands in first cycle, branch in second
            call_second <= take_call;
            BUSY_O <= take_call;
            DONE_O <= call_second || (take && REQ_I.op != cce_pkg::OP_CALL && REQ_I.op != cce_pkg::OP_NONE);
            PUSH_O <= take_call;
            PC_LOAD_O <= call_second;
            if (take_call)
            begin
                PUSH_DATA_O <= PC_I + cce_pkg::PC_STEP;
                PC_O <= REQ_I.target;
            end
        end
    end

    // ==========================================
    // Data memory writes
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            MEM_O <= '{we: 1'b0, addr: cce_pkg::DADDR_RESET, data: cce_pkg::ZERO_BYTE};
        end
        else
        begin
            MEM_O.we <= take_mem_zero || take_bit_zero;
            MEM_O.addr <= REQ_I.addr;
            if (REQ_I.op == cce_pkg::OP_BIT_ZERO)
            begin
                // Read-modify-write keeps the other seven bits
                MEM_O.data <= MEM_RDATA_I & ~(cce_pkg::DATA_W'(1) << REQ_I.bit_sel);
            end
            else
            begin
                MEM_O.data <= cce_pkg::ZERO_BYTE;
            end
        end
    end

    // ==========================================
    // Watchdog clears; no status flag besides these two is touched
    always_ff @(posedge SYS_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            WDT_CLEAR_O <= 1'b0;
            TIMEOUT_CLR_O <= 1'b0;
            POWERDOWN_CLR_O <= 1'b0;
        end
        else
        begin
            WDT_CLEAR_O <= wd_clear;
            TIMEOUT_CLR_O <= wd_clear;
            POWERDOWN_CLR_O <= wd_clear;
        end
    end

    // ==========================================
    // Checks
    sequence call_taken_s;
        take_call;
    endsequence

    sequence call_push_s;
        BUSY_O && PUSH_O && !PC_LOAD_O && !DONE_O;
    endsequence

    sequence call_branch_s;
        PC_LOAD_O && DONE_O && !BUSY_O && !PUSH_O;
    endsequence

    chk_call_push_value: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        call_taken_s |=> PUSH_O && PUSH_DATA_O == $past(PC_I) + cce_pkg::PC_STEP)
        else $error("call push value wrong");
    chk_call_two_cycles: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        call_taken_s |=> BUSY_O && !PC_LOAD_O ##1 PC_LOAD_O && DONE_O && PC_O == $past(REQ_I.target, 2))
        else $error("call branch timing wrong");
    chk_mem_zero_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take && REQ_I.op == cce_pkg::OP_MEM_ZERO |=> MEM_O.we && MEM_O.data == cce_pkg::ZERO_BYTE)
        else $error("memory clear not zero");
    chk_bit_zero_write: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take && REQ_I.op == cce_pkg::OP_BIT_ZERO |=> MEM_O.we
        && MEM_O.data == ($past(MEM_RDATA_I) & ~(cce_pkg::DATA_W'(1) << $past(REQ_I.bit_sel))))
        else $error("bit clear wrong");
    chk_wd_clear_flags: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take && REQ_I.op == cce_pkg::OP_WD_CLEAR |=> WDT_CLEAR_O && TIMEOUT_CLR_O && POWERDOWN_CLR_O)
        else $error("watchdog clear missing");
    chk_pre_single_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take && REQ_I.op == cce_pkg::OP_WD_PRE1 ##1 take && REQ_I.op == cce_pkg::OP_WD_PRE1 |=> !WDT_CLEAR_O)
        else $error("repeated pre-clear cleared watchdog");
    chk_call_step_order: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        call_taken_s |=> call_push_s ##1 call_branch_s)
        else $error("call steps out of order");
    chk_busy_refuses: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        BUSY_O && REQ_VALID_I |=> !MEM_O.we && !PUSH_O && !BUSY_O && !WDT_CLEAR_O)
        else $error("request in second call cycle acted on");
    chk_call_flags_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        call_taken_s |=> !WDT_CLEAR_O && !MEM_O.we ##1 !WDT_CLEAR_O && !MEM_O.we)
        else $error("call touched memory or watchdog");
    chk_push_one_cycle: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        PUSH_O |=> !PUSH_O)
        else $error("push longer than one cycle");
    chk_pc_holds: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        !take_call |=> $stable(PC_O) && $stable(PUSH_DATA_O))
        else $error("call target or return address moved");
    chk_mem_zero_addr: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_mem_zero |=> MEM_O.addr == $past(REQ_I.addr) && DONE_O)
        else $error("memory clear address wrong");
    chk_bit_zero_addr: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_bit_zero |=> MEM_O.addr == $past(REQ_I.addr) && DONE_O)
        else $error("bit clear address wrong");
    chk_mem_write_only: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        !take_mem_zero && !take_bit_zero |=> !MEM_O.we)
        else $error("stray memory write");
    chk_mem_op_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_mem_zero || take_bit_zero |=> !WDT_CLEAR_O && !PUSH_O && !PC_LOAD_O)
        else $error("memory clear touched other state");
    chk_wd_clear_done: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_wd_clear |=> DONE_O && !MEM_O.we && !PUSH_O)
        else $error("watchdog clear completion wrong");
    chk_wd_no_stray: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        !take_wd_clear && !take_pre1 && !take_pre2 |=> !WDT_CLEAR_O && !TIMEOUT_CLR_O && !POWERDOWN_CLR_O)
        else $error("watchdog cleared without an operation");
    chk_pre_done: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_pre1 || take_pre2 |=> DONE_O && !MEM_O.we)
        else $error("pre-clear completion wrong");
    chk_pre_pair_forward: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_pre1 ##1 take_pre2 |=> WDT_CLEAR_O && TIMEOUT_CLR_O && POWERDOWN_CLR_O)
        else $error("first then second pre-clear did not clear");
    chk_pre_pair_reverse: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_pre2 ##1 take_pre1 |=> WDT_CLEAR_O && TIMEOUT_CLR_O && POWERDOWN_CLR_O)
        else $error("second then first pre-clear did not clear");
    chk_pre_second_quiet: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
        take_pre2 ##1 take_pre2 |=> !WDT_CLEAR_O && !TIMEOUT_CLR_O && !POWERDOWN_CLR_O)
        else $error("repeated second pre-clear cleared watchdog");
endmodule

// ---- tb/cce_exec_tb_top.sv ----
// Self-checking testbench for the call and clear execution block
`timescale 1ns/1ps
module cce_exec_tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic valid = 1'b0;
    cce_pkg::cce_req_type req = '0;
    logic [cce_pkg::PC_W-1:0] pc = 11'h000;
    logic [7:0] rdata = 8'h00;
    logic busy, done, pc_load, push, wclr, tclr, pclr;
    logic [cce_pkg::PC_W-1:0] pc_o, push_data, t, e;
    logic [7:0] a;
    cce_pkg::cce_mem_type mem;
    cce_pkg::cce_op_type last, ops [9];
    logic ex;
    int error_cnt = 0;
    int checked = 0;
    int seed = 32'hE49B5E48;

    cce_exec i_cce_exec (.SYS_CLK_I(clk), .NRST_I(nrst), .REQ_VALID_I(valid), .REQ_I(req), .PC_I(pc),
        .MEM_RDATA_I(rdata), .BUSY_O(busy), .DONE_O(done), .PC_LOAD_O(pc_load), .PC_O(pc_o), .PUSH_O(push),
        .PUSH_DATA_O(push_data), .MEM_O(mem), .WDT_CLEAR_O(wclr), .TIMEOUT_CLR_O(tclr), .POWERDOWN_CLR_O(pclr));

    // ==========================================
    // Clock, helpers
    always #25 clk = ~clk;

    task cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle request; returns just after the answer edge, hold leaves valid up for a follow-on
    task issue(input cce_pkg::cce_op_type op, input logic [10:0] tg, input logic [7:0] ad, input logic [2:0] bs,
        input logic hold = 1'b0);
        @(posedge clk);
        #5;
        valid = 1'b1;
        req = '{op, tg, ad, bs};
        @(posedge clk);
        #5;
        if (!hold)
            valid = 1'b0;
    endtask

    function logic fire_exp(input cce_pkg::cce_op_type l, input cce_pkg::cce_op_type op);
        return (op == cce_pkg::OP_WD_PRE1 && l == cce_pkg::OP_WD_PRE2) ||
            (op == cce_pkg::OP_WD_PRE2 && l == cce_pkg::OP_WD_PRE1);
    endfunction

    task end_sim;
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Nothing here waits on a handshake, so a plain limit cuts a hang short
    initial
    begin
        #2000000;
        error_cnt++;
        end_sim;
    end

    // ==========================================
    // Scenarios
    initial
    begin
        ops = '{cce_pkg::OP_WD_PRE1, cce_pkg::OP_WD_PRE1, cce_pkg::OP_MEM_ZERO, cce_pkg::OP_WD_PRE2,
            cce_pkg::OP_WD_PRE2, cce_pkg::OP_WD_PRE1, cce_pkg::OP_WD_PRE2, cce_pkg::OP_NONE, cce_pkg::OP_WD_PRE1};
        repeat (5) @(posedge clk);
        #5;
        nrst = 1'b1;
        for (int k = 0; k < 4; k++)
        begin
            pc = (k == 0) ? 11'h7FF : 11'($random(seed));
            t = 11'($random(seed));
            e = pc + cce_pkg::PC_STEP;
            issue(cce_pkg::OP_CALL, t, 8'h00, 3'h0, 1'b1);
            cmp(push, 1'b1);
            cmp(push_data, e);
            cmp({busy, pc_load}, 2'b10);
            // A request in the second call cycle must be dropped
            req.op = cce_pkg::OP_MEM_ZERO;
            @(posedge clk);
            #5;
            valid = 1'b0;
            cmp({pc_load, done, busy, mem.we}, 4'b1100);
            cmp(pc_o, t);
        end
        $display("call test done");
        for (int k = 0; k < 12; k++)
        begin
            a = 8'($random(seed));
            rdata = 8'($random(seed));
            issue((k < 4) ? cce_pkg::OP_MEM_ZERO : cce_pkg::OP_BIT_ZERO, 11'h000, a, 3'(k));
            cmp({mem.we, done, mem.addr}, {2'b11, a});
            cmp(mem.data, (k < 4) ? 8'h00 : rdata & ~(8'h01 << k[2:0]));
            cmp({wclr, tclr, pclr, push, pc_load}, 5'h00);
        end
        $display("memory clear test done");
        issue(cce_pkg::OP_WD_CLEAR, 11'h000, 8'h00, 3'h0);
        cmp({wclr, tclr, pclr, done, mem.we}, 5'b11110);
        last = cce_pkg::OP_NONE;
        for (int k = 0; k < 9; k++)
        begin
            issue(ops[k], 11'h000, 8'h00, 3'h0, k == 8);
            ex = fire_exp(last, ops[k]);
            cmp({wclr, tclr, pclr}, {ex, ex, ex});
            if (ops[k] == cce_pkg::OP_WD_PRE1 || ops[k] == cce_pkg::OP_WD_PRE2)
                last = ops[k];
        end
        // Same list back to back, valid held high between requests
        for (int k = 0; k < 9; k++)
        begin
            req.op = ops[k];
            @(posedge clk);
            #5;
            ex = fire_exp(last, ops[k]);
            cmp({wclr, tclr, pclr}, {ex, ex, ex});
            if (ops[k] == cce_pkg::OP_WD_PRE1 || ops[k] == cce_pkg::OP_WD_PRE2)
                last = ops[k];
        end
        valid = 1'b0;
        // Reset after a first pre-clear must forget it
        nrst = 1'b0;
        #5;
        cmp({busy, done, pc_load, push, wclr, mem.we}, 6'h00);
        @(posedge clk);
        #5;
        nrst = 1'b1;
        issue(cce_pkg::OP_WD_PRE2, 11'h000, 8'h00, 3'h0);
        cmp({wclr, tclr, pclr}, 3'b000);
        issue(cce_pkg::OP_WD_PRE1, 11'h000, 8'h00, 3'h0);
        cmp({wclr, tclr, pclr}, 3'b111);
        $display("watchdog test done");
        end_sim;
    end
endmodule
